// File: rtl/psc_regs.sv
// psc_regs: status, control and resume-flag registers of the power manager.
// assumes inputs synchronous to core_clk_in; sequencer lives outside and reports its state here.
//
// Notes on behaviour
// - status bit 7 reports seal broken
// - status bit 6 reports defaults changed
// - bit 5 set while adapter pin low
// - bit 4 set while button pin low
// - bits 3-2 encode sequencer state
// - bits 1-0 encode coin cell charge
// - charge field valid only after measurement
// - control bit 0 triggers measurement, self-clears
// - enabled power-fail trip shuts everything off
// - disabled power-fail bit ignores comparator
// - flags 3-0: bucks kept on in suspend
// - flag 4: linear reg kept on
// - flags 7-5: general outputs kept on
// - flags clear on cold start, reset zero
`default_nettype none
module psc_regs
  import psc_pkg::*;
(
  input  wire logic          core_clk_in,
  input  wire logic          rstn_in,
  input  wire psc_req_type   req_in,
  output logic [7:0]         rdata_out,
  input  wire logic          seal_broken_in,
  input  wire logic          nvm_changed_in,
  input  wire logic          adapter_detect_pin_n_in,
  input  wire logic          push_button_pin_n_in,
  input  wire logic [1:0]    seq_state_in,
  input  wire logic          powerup_in,
  input  wire logic          from_suspend_in,
  input  wire psc_rails_type rails_en_in,
  input  wire logic          powerfail_out_n_in,
  input  wire logic          measure_done_in,
  input  wire logic [1:0]    cell_level_in,
  output logic               cell_measure_trigger_out,
  output logic               shutdown_all_out,
  output psc_pwr_type        pwr_state_out
);

  // control word
  logic                   pfsd_r;
  logic                   pfsd_nxt;
  logic                   trig_r;
  logic                   trig_nxt;

  // coin cell result
  logic [PSC_FIELD_W-1:0] cell_r;
  logic [PSC_FIELD_W-1:0] cell_nxt;
  logic                   cell_valid_r;
  logic                   cell_valid_nxt;

  // power tracking
  psc_pwr_type            pwr_r;
  psc_pwr_type            pwr_nxt;
  logic                   shut_r;
  logic                   shut_nxt;

  // resume flags
  logic [PSC_RAILS-1:0]   flags_w;
  logic [PSC_RAILS-1:0]   rails_w;

  // readback
  logic [7:0]             rdata_r;
  logic [7:0]             rdata_nxt;
  logic [7:0]             status_w;
  logic [7:0]             control_w;

  // decoded events
  logic                   ctrl_wr_w;
  logic                   trip_w;
  logic                   wake_w;
  logic                   cold_w;

  // only the control word is writable; status and flag writes drop silently
  assign ctrl_wr_w = req_in.wr && (req_in.addr == PSC_CONTROL_ADDR);
  // comparator only acts when shutdown enabled; otherwise state untouched
  assign trip_w    = pfsd_r && !powerfail_out_n_in;
  assign wake_w    = powerup_in && from_suspend_in && (pwr_r == PSC_PWR_SUSPEND);
  assign cold_w    = powerup_in && !wake_w;
  assign rails_w   = rails_en_in;

  always_comb begin
    pfsd_nxt = pfsd_r;
    trig_nxt = 1'h0;
    if (ctrl_wr_w) begin
      pfsd_nxt = req_in.wdata[PSC_PFSD_BIT];
      // a written zero simply leaves the trigger idle
      trig_nxt = req_in.wdata[PSC_TRIG_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pfsd_r <= PSC_CONTROL_RST[PSC_PFSD_BIT];
      trig_r <= PSC_CONTROL_RST[PSC_TRIG_BIT];
    end else begin
      pfsd_r <= pfsd_nxt;
      trig_r <= trig_nxt;
    end
  end

  always_comb begin
    cell_nxt       = cell_r;
    cell_valid_nxt = cell_valid_r;
    // field updates only from a completed acquisition, not from the trigger
    if (measure_done_in) begin
      cell_nxt       = cell_level_in;
      cell_valid_nxt = 1'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cell_r       <= PSC_CELL_RST;
      cell_valid_r <= 1'h0;
    end else begin
      cell_r       <= cell_nxt;
      cell_valid_r <= cell_valid_nxt;
    end
  end

  always_comb begin
    pwr_nxt  = pwr_r;
    shut_nxt = 1'h0;
    if (powerup_in) begin
      pwr_nxt = PSC_PWR_ON;
    end else if (seq_state_in == PSC_SEQ_SUSPEND) begin
      pwr_nxt = PSC_PWR_SUSPEND;
    end
    // a trip wins over a power-up in the same cycle
    if (trip_w) begin
      shut_nxt = 1'h1;
      pwr_nxt  = PSC_PWR_OFF;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      shut_r <= 1'h0;
      pwr_r  <= PSC_PWR_OFF;
    end else begin
      shut_r <= shut_nxt;
      pwr_r  <= pwr_nxt;
    end
  end

  // one capture cell per rail; each only moves on a power-up event
  generate
    for (genvar gi = 0; gi < PSC_RAILS; gi++) begin : g_flag
      logic flag_r;
      logic flag_nxt;

      always_comb begin
        flag_nxt = flag_r;
        if (wake_w) begin
          flag_nxt = rails_w[gi];
        end else if (cold_w) begin
          flag_nxt = PSC_FLAG_RST[gi];
        end
      end

      always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
          flag_r <= PSC_FLAG_RST[gi];
        end else begin
          flag_r <= flag_nxt;
        end
      end

      assign flags_w[gi] = flag_r;
    end
  endgenerate

  always_comb begin
    status_w                               = PSC_ZERO;
    status_w[PSC_SEAL_BIT]                 = seal_broken_in;
    status_w[PSC_NVM_BIT]                  = nvm_changed_in;
    status_w[PSC_ADAPT_BIT]                = ~adapter_detect_pin_n_in;
    status_w[PSC_BUTTON_BIT]               = ~push_button_pin_n_in;
    status_w[PSC_STATE_LSB +: PSC_FIELD_W] = seq_state_in;
    // cell field reads zero until a measurement has landed
    status_w[PSC_CELL_LSB +: PSC_FIELD_W]  = cell_valid_r ? cell_r : PSC_CELL_RST;
    control_w                              = PSC_ZERO;
    control_w[PSC_PFSD_BIT]                = pfsd_r;
    control_w[PSC_TRIG_BIT]                = trig_r;
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (req_in.rd) begin
      unique case (req_in.addr)
        PSC_STATUS_ADDR: begin
          rdata_nxt = status_w;
        end
        PSC_CONTROL_ADDR: begin
          rdata_nxt = control_w;
        end
        PSC_FLAG_ADDR: begin
          rdata_nxt = flags_w;
        end
        default: begin
          // unmapped reads return zero rather than the last value
          rdata_nxt = PSC_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rdata_r <= PSC_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out                = rdata_r;
  assign cell_measure_trigger_out = trig_r;
  assign shutdown_all_out         = shut_r;
  assign pwr_state_out            = pwr_r;

endmodule // psc_regs
`default_nettype wire

// File: include/psc_pkg.sv
// psc_pkg: register map, field positions and sequencer codes for the status/control/flag group.
// assumes one register access port driven by an external serial-bus front end.
`default_nettype none
package psc_pkg;
  localparam logic [7:0] PSC_STATUS_ADDR  = 8'h05;
  localparam logic [7:0] PSC_CONTROL_ADDR = 8'h06;
  localparam logic [7:0] PSC_FLAG_ADDR    = 8'h07;
  localparam logic [7:0] PSC_CONTROL_RST  = 8'h00;
  localparam logic [7:0] PSC_FLAG_RST     = 8'h00;
  localparam logic [7:0] PSC_ZERO         = 8'h00;
  localparam int PSC_SEAL_BIT   = 7;
  localparam int PSC_NVM_BIT    = 6;
  localparam int PSC_ADAPT_BIT  = 5;
  localparam int PSC_BUTTON_BIT = 4;
  localparam int PSC_TRIG_BIT   = 0;
  localparam int PSC_PFSD_BIT   = 1;
  localparam int PSC_RAILS      = 8;
  localparam int PSC_STATE_LSB  = 2;
  localparam int PSC_CELL_LSB   = 0;
  localparam int PSC_FIELD_W    = 2;
  localparam logic [1:0] PSC_CELL_RST = 2'h0;
  // sequencer state codes as reported in the status word
  localparam logic [1:0] PSC_SEQ_TRANSIT = 2'h0;
  localparam logic [1:0] PSC_SEQ_AWAIT   = 2'h1;
  localparam logic [1:0] PSC_SEQ_ACTIVE  = 2'h2;
  localparam logic [1:0] PSC_SEQ_SUSPEND = 2'h3;

  typedef enum logic [2:0] {
    PSC_PWR_OFF     = 3'b001,
    PSC_PWR_ON      = 3'b010,
    PSC_PWR_SUSPEND = 3'b100
  } psc_pwr_type;

  // register access request from the bus front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psc_req_type;

  // rail enables: [3:0] bucks 4..1, [4] linear reg, [7:5] general outs 3..1
  typedef struct packed {
    logic [2:0] outs;
    logic       linreg;
    logic [3:0] bucks;
  } psc_rails_type;
endpackage
`default_nettype wire

// File: testbench/psc_regs_properties.sv
// psc_regs_chk: port timing properties of psc_regs.
// bound into every psc_regs instance.
`default_nettype none
module psc_regs_chk
  import psc_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  input wire psc_req_type req_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        seal_broken_in,
  input wire logic        nvm_changed_in,
  input wire logic        adapter_detect_pin_n_in,
  input wire logic        push_button_pin_n_in,
  input wire logic [1:0]  seq_state_in,
  input wire logic        powerfail_out_n_in,
  input wire logic        cell_measure_trigger_out,
  input wire logic        shutdown_all_out,
  input wire psc_pwr_type pwr_state_out
);
  wire logic trig_wr = req_in.wr && req_in.addr == PSC_CONTROL_ADDR && req_in.wdata[PSC_TRIG_BIT];
  wire logic st = req_in.rd && req_in.addr == PSC_STATUS_ADDR;
  wire logic ct = req_in.rd && req_in.addr == PSC_CONTROL_ADDR;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_pulse; cell_measure_trigger_out ##1 !cell_measure_trigger_out; endsequence
  a_trig_start: assert property (trig_wr ##1 !trig_wr |-> s_pulse) else $error("trigger");
  a_trig_cause: assert property (cell_measure_trigger_out |-> $past(trig_wr)) else $error("stray");
  a_trip_off: assert property (shutdown_all_out |-> pwr_state_out == PSC_PWR_OFF) else $error("trip");
  a_trip_cause: assert property (shutdown_all_out |-> !$past(powerfail_out_n_in)) else $error("no fail");
  a_seal_bit: assert property (st |=> rdata_out[PSC_SEAL_BIT] == $past(seal_broken_in)) else $error("seal");
  a_nvm_bit: assert property (st |=> rdata_out[PSC_NVM_BIT] == $past(nvm_changed_in)) else $error("nvm");
  a_adapt_bit: assert property (st |=> rdata_out[5] != $past(adapter_detect_pin_n_in)) else $error("ac");
  a_button_bit: assert property (st |=> rdata_out[4] != $past(push_button_pin_n_in)) else $error("pb");
  a_state_code: assert property (st |=> rdata_out[3:2] == $past(seq_state_in)) else $error("state");
  a_ctrl_resv: assert property (ct |=> rdata_out[7:2] == 6'h00) else $error("resv");
  a_unmapped_zero: assert property (req_in.rd && req_in.addr > 8'h07 |=> rdata_out == PSC_ZERO) else $error("map");
endmodule // psc_regs_chk
bind psc_regs psc_regs_chk psc_regs_chk_i (.*);
`default_nettype wire

// File: testbench/psc_cell_model.sv
// psc_cell_model: coin-cell measurement front end.
// answers a one-cycle trigger three cycles later.
`default_nettype none
module psc_cell_model (
  input  wire logic       clk_in,
  input  wire logic       trig_in,
  input  wire logic [1:0] level_in,
  output logic            done_out,
  output logic [1:0]      cell_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk_in) begin
    {done_out, cell_out} <= {1'h0, ~level_in}; // idle lines hold no stale result
    if (trig_in === 1'h1) begin
      repeat (3) @(posedge clk_in);
      {done_out, cell_out} <= {1'h1, level_in};
    end
  end
endmodule // psc_cell_model
`default_nettype wire

// File: testbench/tb_top.sv
// tb_top: self-checking bench for psc_regs and the cell model.
// 20 MHz clock; reads checked in order from a queue.
`default_nettype none
module tb_top;
  import psc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = '0, rstn_in = '0, seal_broken_in = '0, nvm_changed_in = '0, adapter_detect_pin_n_in = '1;
  logic push_button_pin_n_in = '1, powerup_in = '0, from_suspend_in = '1, powerfail_out_n_in = '1, rd_d = '0;
  logic measure_done_in, cell_measure_trigger_out, shutdown_all_out;
  logic [1:0] seq_state_in = '0, lvl = '0, cell_level_in;
  logic [7:0] rdata_out, s, q[$];
  psc_req_type req_in = '0;
  psc_rails_type rails_en_in = '0;
  psc_pwr_type pwr_state_out;
  int seed = 24910, num_errors = 0, cmp_count = 0, x, k;
  psc_regs psc_regs_i (.*);
  psc_cell_model psc_cell_model_i (.clk_in(core_clk_in), .trig_in(cell_measure_trigger_out), .level_in(lvl),
    .done_out(measure_done_in), .cell_out(cell_level_in));
  initial forever #25 core_clk_in = ~core_clk_in;
  task automatic chk(input string n, input logic [7:0] sv, ev);
    cmp_count++;
    if (sv !== ev) begin num_errors++; $display("CHECK FAILED %s exp %h seen %h", n, ev, sv); end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d, e);
    @(posedge core_clk_in) req_in <= '{w, !w, a, d};
    if (!w) q.push_back(e);
    @(posedge core_clk_in) req_in <= '0;
  endtask
  always @(posedge core_clk_in) begin
    if (rd_d) chk("rdata", rdata_out, q.pop_front());
    rd_d <= req_in.rd;
  end
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    rstn_in <= '1;
    bus(0, PSC_CONTROL_ADDR, 0, PSC_CONTROL_RST);
    bus(0, PSC_FLAG_ADDR, 0, PSC_FLAG_RST);
    bus(0, 8'h20, 0, PSC_ZERO);
    for (int i = 3; i >= 0; i--) begin
      x = $random(seed);
      {seal_broken_in, nvm_changed_in, adapter_detect_pin_n_in, push_button_pin_n_in} <= x[3:0];
      seq_state_in <= i[1:0];
      s = {x[3:2], ~x[1:0], i[1:0], 2'h0};
      bus(0, PSC_STATUS_ADDR, 0, s);
    end
    {powerup_in, from_suspend_in, rails_en_in} <= {1'h1, 1'h0, 8'hff};
    @(posedge core_clk_in) {powerup_in, from_suspend_in} <= {1'h0, 1'h1};
    bus(0, PSC_FLAG_ADDR, 0, PSC_ZERO);
    powerfail_out_n_in <= '0;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in) chk("pfsd off", {shutdown_all_out, pwr_state_out}, {1'h0, PSC_PWR_ON});
    @(posedge core_clk_in) {powerfail_out_n_in, seq_state_in} <= {1'h1, PSC_SEQ_SUSPEND};
    x = $random(seed);
    repeat (2) @(posedge core_clk_in);
    {rails_en_in, powerup_in, lvl} <= {x[7:0], 1'h1, x[9:8]};
    @(posedge core_clk_in) {rails_en_in, powerup_in} <= {~x[7:0], 1'h0};
    bus(0, PSC_FLAG_ADDR, 0, x[7:0]);
    bus(1, PSC_FLAG_ADDR, 8'hff, 0);
    bus(0, PSC_FLAG_ADDR, 0, x[7:0]);
    bus(1, PSC_CONTROL_ADDR, 8'hff, 0);
    for (k = 0; k < 20 && measure_done_in !== 1'h1; k++) @(posedge core_clk_in);
    if (measure_done_in !== 1'h1) begin num_errors++; stop_test(); end
    bus(0, PSC_STATUS_ADDR, 0, {s[7:4], PSC_SEQ_SUSPEND, x[9:8]});
    bus(0, PSC_CONTROL_ADDR, 0, 8'h02);
    powerfail_out_n_in <= '0;
    @(posedge core_clk_in);
    @(negedge core_clk_in) chk("pfsd on", {shutdown_all_out, pwr_state_out}, {1'h1, PSC_PWR_OFF});
    @(posedge core_clk_in) rstn_in <= '0;
    repeat (2) @(posedge core_clk_in);
    rstn_in <= '1;
    bus(0, PSC_FLAG_ADDR, 0, PSC_FLAG_RST);
    bus(0, PSC_STATUS_ADDR, 0, {s[7:4], PSC_SEQ_SUSPEND, PSC_CELL_RST});
    @(negedge core_clk_in) chk("reset trip", {shutdown_all_out, pwr_state_out}, {1'h0, PSC_PWR_SUSPEND});
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
